// [design/status_word_params.svh]
// Constants for the status word execution-state unit: offsets, field
// positions, reset values and exception numbers.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef STATUS_WORD_PARAMS_SVH
`define STATUS_WORD_PARAMS_SVH

// ==========================================================================
// Register offsets on the plain register port
// ==========================================================================
`define SW_ADDR_W            4
`define SW_OFF_PSW           4'h0
`define SW_OFF_CTRL          4'h4
`define SW_OFF_STAT          4'h8

// ==========================================================================
// Field positions inside the program status word
// ==========================================================================
`define SW_ISA_BIT           24
`define SW_EXEC_HI_MSB       26
`define SW_EXEC_HI_LSB       25
`define SW_EXEC_LO_MSB       15
`define SW_EXEC_LO_LSB       10
`define SW_ICI_MSB           15
`define SW_ICI_LSB           12
`define SW_EXC_MSB           5
`define SW_EXC_LSB           0

// ==========================================================================
// Control and status bit positions
// ==========================================================================
`define SW_CTRL_LOCKUP_BIT   0
`define SW_STAT_FAULT_BIT    0
`define SW_STAT_LOCKUP_BIT   1
`define SW_STAT_BADEXC_BIT   2

// ==========================================================================
// Reset values
// ==========================================================================
`define SW_RST_ISA           1'b1
`define SW_RST_EXEC          8'h00
`define SW_RST_EXC           6'h00
`define SW_RST_CTRL          1'b0

// ==========================================================================
// Exception numbers
// ==========================================================================
`define SW_EXC_THREAD        6'h00
`define SW_EXC_NMI           6'h02
`define SW_EXC_HARD          6'h03
`define SW_EXC_MEM           6'h04
`define SW_EXC_BUS           6'h05
`define SW_EXC_USAGE         6'h06
`define SW_EXC_SVC           6'h0b
`define SW_EXC_PENDABLE_SERVICE_EXCEPTION        6'h0e
`define SW_EXC_TICK          6'h0f
`define SW_EXC_IRQ_BASE      6'h10
`define SW_EXC_IRQ_LAST      6'h2d

`endif

// [design/status_word_pkg.sv]
// Types shared by the status word execution-state unit.
// Assumes the constants header is available by bare name.
package status_word_pkg;

  // ========================================================================
  // Run state and exception kinds
  // ========================================================================
  typedef enum logic [0:0] {
    MODE_RUN    = 1'b0,
    MODE_LOCKUP = 1'b1
  } exec_mode_t;

  typedef enum logic [2:0] {
    KIND_THREAD   = 3'b000,
    KIND_FIXED    = 3'b001,
    KIND_FAULT    = 3'b010,
    KIND_SYSTEM   = 3'b011,
    KIND_IRQ      = 3'b100,
    KIND_RESERVED = 3'b111
  } exc_kind_t;

endpackage : status_word_pkg

// [design/exc_class_if.sv]
// Carrier between the status word unit and its exception classifier.
// Assumes both ends share one clock; the carrier is purely combinational.
`timescale 1ns/1ps
`default_nettype none

interface exc_class_if;
  import status_word_pkg::*;
  logic [5:0]  number;
  exc_kind_t   kind;
  logic        reserved;
  logic [4:0]  irq_index;

  modport user (output number, input kind, input reserved, input irq_index);
  modport decoder (input number, output kind, output reserved, output irq_index);
endinterface : exc_class_if

`default_nettype wire

// [design/exc_number_classifier.sv]
// Decodes an active exception number into its kind and interrupt index.
// Assumes a combinational caller on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "status_word_params.svh"

module exc_number_classifier (
  exc_class_if.decoder cls
);
  import status_word_pkg::*;

  // Maps every code; anything not listed is reserved.
  always_comb begin
    cls.kind      = KIND_RESERVED;
    cls.irq_index = 5'h00;
    case (cls.number)
      `SW_EXC_THREAD: cls.kind = KIND_THREAD;
      `SW_EXC_NMI,
      `SW_EXC_HARD: cls.kind = KIND_FIXED;
      `SW_EXC_MEM,
      `SW_EXC_BUS,
      `SW_EXC_USAGE: cls.kind = KIND_FAULT;
      `SW_EXC_SVC,
      `SW_EXC_PENDABLE_SERVICE_EXCEPTION,
      `SW_EXC_TICK: cls.kind = KIND_SYSTEM;
      default: begin
        if (cls.number >= `SW_EXC_IRQ_BASE && cls.number <= `SW_EXC_IRQ_LAST) begin
          cls.kind      = KIND_IRQ;
          cls.irq_index = 5'(cls.number - `SW_EXC_IRQ_BASE);
        end
      end
    endcase
    cls.reserved = (cls.kind == KIND_RESERVED);
  end

endmodule : exc_number_classifier

`default_nettype wire

// [design/status_word_exec_state.sv]
// Execution and interrupt state fields of the program status word.
// Assumes all event inputs come from core logic on clk_i, each a one-cycle
// pulse, and that the register port follows the plain strobe protocol.
//
// Behaviour
// (RULE_01) Branch exchanges and PC pops load state bit.
// (RULE_02) Exception return reloads state bit from stack.
// (RULE_03) Entry and reset load state from vector bit0.
// (RULE_04) Executing with state bit clear faults or locks.
// (RULE_05) Bits 23:16 and 9:6 read zero.
// (RULE_06) Execution state lives in bits 15:10, 26:25.
// (RULE_07) Interrupted multiple transfer records next register.
// (RULE_08) Return resumes transfer at recorded register.
// (RULE_09) Continuable state keeps bits 11:10 zero.
// (RULE_10) Conditional block up to four instructions.
// (RULE_11) Bits 5:0 report running exception number.
// (RULE_12) Other exception codes decoded; rest reserved.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "status_word_params.svh"

module status_word_exec_state (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  // Register port.
  input  wire logic [`SW_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  // Core events.
  input  wire logic                   reset_vector_i,
  input  wire logic                   exc_entry_i,
  input  wire logic [5:0]             exc_number_i,
  input  wire logic [31:0]            vector_value_i,
  input  wire logic                   exc_return_i,
  input  wire logic [31:0]            stacked_status_word_i,
  input  wire logic                   branch_exchange_i,
  input  wire logic [31:0]            branch_target_i,
  input  wire logic                   exec_attempt_i,
  input  wire logic                   multi_active_i,
  input  wire logic [3:0]             multi_next_reg_i,
  input  wire logic                   cond_block_start_i,
  input  wire logic [3:0]             cond_block_first_i,
  input  wire logic [3:0]             cond_block_mask_i,
  input  wire logic                   cond_block_step_i,
  // Status to the core.
  output logic      [31:0]            status_word_o,
  output logic                        exec_allowed_o,
  output logic                        fault_o,
  output logic                        lockup_o,
  output logic                        resume_valid_o,
  output logic      [3:0]             resume_reg_o,
  output logic                        in_cond_block_o,
  output logic      [3:0]             cond_code_o,
  output status_word_pkg::exc_kind_t  exc_kind_o,
  output logic      [4:0]             irq_index_o
);
  import status_word_pkg::*;

  // ========================================================================
  // State
  // ========================================================================
  logic         isa_state_reg;
  logic [7:0]   exec_state_reg;   // {lo 15:10, hi 26:25} packed as [7:2],[1:0].
  logic [5:0]   exc_number_reg;
  exec_mode_t   mode_reg;
  logic         lockup_en_reg;
  logic         fault_seen_reg;
  logic         bad_exc_reg;
  logic [31:0]  psw_view;
  logic         entry_ok;
  logic         fault_now;
  logic         lock_now;
  logic         stacked_is_ici;
  logic         exec_is_ici;

  exc_class_if  cur_cls ();
  exc_class_if  new_cls ();

  // ========================================================================
  // Exception number decoding
  // ========================================================================
  // One decoder watches the running number, one the number being entered.
  exc_number_classifier u_cur_cls (
    .cls (cur_cls.decoder)
  );
  exc_number_classifier u_new_cls (
    .cls (new_cls.decoder)
  );

  assign cur_cls.number = exc_number_reg;
  assign new_cls.number = exc_number_i;
  // A reserved number cannot start a handler; the entry is refused.
  assign entry_ok = exc_entry_i && !new_cls.reserved; // [RULE_12]

  // ========================================================================
  // Instruction-set state bit
  // ========================================================================
  // Reset vector and entry win over return, which wins over branches.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      isa_state_reg <= `SW_RST_ISA;
    end else if (reset_vector_i || entry_ok) begin
      isa_state_reg <= vector_value_i[0]; // [RULE_03]
    end else if (exc_return_i) begin
      isa_state_reg <= stacked_status_word_i[`SW_ISA_BIT]; // [RULE_02]
    end else if (branch_exchange_i) begin
      isa_state_reg <= branch_target_i[0]; // [RULE_01]
    end
  end

  // ========================================================================
  // Continuable-instruction and conditional-block state
  // ========================================================================
  // Stacked state counts as continuable when both condition slices are zero and bits 15:12 are not.
  assign stacked_is_ici = (stacked_status_word_i[`SW_EXEC_HI_MSB:`SW_EXEC_HI_LSB] == 2'b00)
                       && (stacked_status_word_i[11:10] == 2'b00)
                       && (stacked_status_word_i[`SW_ICI_MSB:`SW_ICI_LSB] != 4'h0);
  assign exec_is_ici = (exec_state_reg[1:0] == 2'b00) && (exec_state_reg[3:2] == 2'b00)
                    && (exec_state_reg[7:4] != 4'h0);

  // Interrupting a multiple transfer records the next operand register.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      exec_state_reg <= `SW_RST_EXEC;
    end else if (reset_vector_i) begin
      exec_state_reg <= `SW_RST_EXEC;
    end else if (entry_ok) begin
      if (multi_active_i) begin
        exec_state_reg <= {multi_next_reg_i, 4'h0}; // [RULE_07] [RULE_09]
      end else begin
        exec_state_reg <= `SW_RST_EXEC;
      end
    end else if (exc_return_i) begin
      exec_state_reg <= {stacked_status_word_i[`SW_EXEC_LO_MSB:`SW_EXEC_LO_LSB],
                         stacked_status_word_i[`SW_EXEC_HI_MSB:`SW_EXEC_HI_LSB]}; // [RULE_06]
    end else if (cond_block_start_i && cond_block_mask_i != 4'h0) begin
      // Layout: first condition in [7:4], mask in [3:0]; mask length sets count.
      exec_state_reg <= {cond_block_first_i, cond_block_mask_i}; // [RULE_10]
    end else if (cond_block_step_i && in_cond_block_o) begin
      if (exec_state_reg[2:0] == 3'b000) begin
        exec_state_reg <= `SW_RST_EXEC; // Last instruction of the block retired.
      end else begin
        exec_state_reg <= {exec_state_reg[7:5], exec_state_reg[3:0], 1'b0}; // [RULE_10]
      end
    end else if (resume_valid_o) begin
      exec_state_reg <= `SW_RST_EXEC; // Transfer resumed; the record is spent.
    end
  end

  // Resume is announced the cycle after a return that restored a record.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      resume_valid_o <= 1'b0;
      resume_reg_o   <= 4'h0;
    end else begin
      resume_valid_o <= exc_return_i && !reset_vector_i && !entry_ok && stacked_is_ici; // [RULE_08]
      resume_reg_o   <= stacked_status_word_i[`SW_ICI_MSB:`SW_ICI_LSB]; // [RULE_08]
    end
  end

  // Conditional block view: active when the mask part is non-zero.
  assign in_cond_block_o = (exec_state_reg[3:0] != 4'h0) && !exec_is_ici;
  assign cond_code_o     = {exec_state_reg[7:5], exec_state_reg[4]};

  // ========================================================================
  // Active exception number
  // ========================================================================
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      exc_number_reg <= `SW_RST_EXC;
    end else if (reset_vector_i) begin
      exc_number_reg <= `SW_EXC_THREAD;
    end else if (entry_ok) begin
      exc_number_reg <= exc_number_i; // [RULE_11]
    end else if (exc_return_i) begin
      exc_number_reg <= stacked_status_word_i[`SW_EXC_MSB:`SW_EXC_LSB]; // [RULE_11]
    end
  end

  assign exc_kind_o  = cur_cls.kind;
  assign irq_index_o = cur_cls.irq_index;

  // ========================================================================
  // Fault and lockup on execution with the state bit clear
  // ========================================================================
  // Faulting inside the fixed-priority handlers cannot escalate, so it locks.
  assign fault_now = exec_attempt_i && !isa_state_reg && (mode_reg == MODE_RUN);
  assign lock_now  = fault_now && (lockup_en_reg || cur_cls.kind == KIND_FIXED); // [RULE_04]

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_reg <= MODE_RUN;
    end else begin
      case (mode_reg)
        MODE_RUN: begin
          if (lock_now) begin
            mode_reg <= MODE_LOCKUP; // [RULE_04]
          end
        end
        MODE_LOCKUP: begin
          mode_reg <= MODE_LOCKUP; // Left only by reset.
        end
        default: begin
          mode_reg <= MODE_RUN;
        end
      endcase
    end
  end

  // Fault is a one-cycle pulse asking the core for a usage fault.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= fault_now && !lock_now; // [RULE_04]
    end
  end

  assign lockup_o       = (mode_reg == MODE_LOCKUP);
  assign exec_allowed_o = isa_state_reg && (mode_reg == MODE_RUN); // [RULE_04]

  // ========================================================================
  // Assembled status word
  // ========================================================================
  // Flags above bit 26 belong elsewhere and read as zero here.
  always_comb begin
    psw_view                                  = 32'h0000_0000; // [RULE_05]
    psw_view[`SW_ISA_BIT]                     = isa_state_reg;
    psw_view[`SW_EXEC_HI_MSB:`SW_EXEC_HI_LSB] = exec_state_reg[1:0]; // [RULE_06]
    psw_view[`SW_EXEC_LO_MSB:`SW_EXEC_LO_LSB] = exec_state_reg[7:2]; // [RULE_06]
    psw_view[`SW_EXC_MSB:`SW_EXC_LSB]         = exc_number_reg; // [RULE_11]
  end

  // Registered copy for the core; used as the word pushed at entry.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      status_word_o <= 32'h0000_0000;
    end else begin
      status_word_o <= psw_view;
    end
  end

  // ========================================================================
  // Register port
  // ========================================================================
  // Control: lockup enable. Writes to the status word itself are ignored.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lockup_en_reg <= `SW_RST_CTRL;
    end else if (reg_wr_i && reg_addr_i == `SW_OFF_CTRL) begin
      lockup_en_reg <= reg_wdata_i[`SW_CTRL_LOCKUP_BIT];
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fault_seen_reg <= 1'b0;
      bad_exc_reg    <= 1'b0;
    end else begin
      if (fault_now) begin
        fault_seen_reg <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `SW_OFF_STAT
                   && reg_wdata_i[`SW_STAT_FAULT_BIT]) begin
        fault_seen_reg <= 1'b0;
      end
      if (exc_entry_i && new_cls.reserved) begin
        bad_exc_reg <= 1'b1; // [RULE_12]
      end else if (reg_wr_i && reg_addr_i == `SW_OFF_STAT
                   && reg_wdata_i[`SW_STAT_BADEXC_BIT]) begin
        bad_exc_reg <= 1'b0;
      end
    end
  end

  // Read data appear in the cycle after the strobe and only there.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SW_OFF_PSW:  reg_rdata_o <= psw_view; // [RULE_05]
        `SW_OFF_CTRL: reg_rdata_o <= {31'h0, lockup_en_reg};
        `SW_OFF_STAT: reg_rdata_o <= {29'h0, bad_exc_reg, lockup_o, fault_seen_reg};
        default:      reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule : status_word_exec_state

`default_nettype wire

// [tb/status_word_monitor.sv]
// Checker for the status word execution-state unit.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "status_word_params.svh"

module status_word_monitor import status_word_pkg::*; (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        reset_vector_i,
  input wire logic        exc_entry_i,
  input wire logic [5:0]  exc_number_i,
  input wire logic [31:0] vector_value_i,
  input wire logic        exc_return_i,
  input wire logic [31:0] stacked_status_word_i,
  input wire logic        branch_exchange_i,
  input wire logic [31:0] branch_target_i,
  input wire logic        exec_attempt_i,
  input wire logic        multi_active_i,
  input wire logic [3:0]  multi_next_reg_i,
  input wire logic        cond_block_start_i,
  input wire logic [3:0]  cond_block_first_i,
  input wire logic [3:0]  cond_block_mask_i,
  input wire logic [31:0] status_word_o,
  input wire logic        exec_allowed_o,
  input wire logic        fault_o,
  input wire logic        lockup_o,
  input wire logic        resume_valid_o,
  input wire logic [3:0]  resume_reg_o,
  input wire logic        in_cond_block_o,
  input wire logic [3:0]  cond_code_o,
  input wire exc_kind_t   exc_kind_o,
  input wire logic [4:0]  irq_index_o
);
  // ========================================================================
  // Helpers
  // ========================================================================
  // Flags the nonzero entry numbers that the unit accepts, and a quiet cycle.
  logic num_ok;
  logic no_exc;
  assign num_ok = exc_number_i inside {[6'h02:6'h06], 6'h0b, [6'h0e:6'h2d]};
  assign no_exc = !reset_vector_i && !exc_entry_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ========================================================================
  // Assertions
  // ========================================================================
  a_branch_sets_state: assert property (
    branch_exchange_i && no_exc && !exc_return_i && !exec_attempt_i && !lockup_o
    |=> exec_allowed_o == $past(branch_target_i[0])) else $error("branch state bit wrong");
  a_return_reload_state: assert property (
    exc_return_i && no_exc |=> ##1 status_word_o[24] == $past(stacked_status_word_i[24], 2))
    else $error("return state bit wrong");
  a_vector_loads_state: assert property (
    reset_vector_i |=> ##1 status_word_o == {7'h00, $past(vector_value_i[0], 2), 24'h000000})
    else $error("reset vector load wrong");
  a_bad_exec_faults: assert property (
    exec_attempt_i && !exec_allowed_o && !reset_vector_i |=> fault_o || lockup_o)
    else $error("bad execution not caught");
  a_reserved_bits_zero: assert property (
    status_word_o[23:16] == 8'h00 && status_word_o[9:6] == 4'h0)
    else $error("reserved bits not zero");
  a_multi_records_next: assert property (
    exc_entry_i && !reset_vector_i && multi_active_i && exc_number_i inside {[6'h10:6'h2d]}
    |=> ##1 status_word_o[15:12] == $past(multi_next_reg_i, 2) && status_word_o[11:10] == 2'b00
    && status_word_o[26:25] == 2'b00) else $error("next register not recorded");
  a_resume_at_reg: assert property (
    exc_return_i && no_exc && stacked_status_word_i[26:25] == 2'b00
    && stacked_status_word_i[11:10] == 2'b00 && stacked_status_word_i[15:12] != 4'h0
    |=> resume_valid_o && resume_reg_o == $past(stacked_status_word_i[15:12]))
    else $error("resume register wrong");
  a_block_start_cond: assert property (
    cond_block_start_i && cond_block_mask_i != 4'h0 && no_exc && !exc_return_i
    |=> in_cond_block_o && cond_code_o == $past(cond_block_first_i))
    else $error("block start wrong");
  a_entry_number_shown: assert property (
    exc_entry_i && !reset_vector_i && num_ok |=> ##1 status_word_o[5:0] == $past(exc_number_i, 2))
    else $error("exception number wrong");
  a_irq_index_match: assert property (
    exc_kind_o == KIND_IRQ |=> status_word_o[5:0] == 6'($past(irq_index_o) + 6'h10))
    else $error("interrupt index wrong");
  // Main scenarios reached.
  c_resume: cover property (resume_valid_o);
  c_fault: cover property (fault_o);
  c_block_end: cover property (in_cond_block_o ##1 !in_cond_block_o);
endmodule : status_word_monitor

bind status_word_exec_state status_word_monitor u_status_word_monitor (.*);

`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench for the status word execution-state unit.
// Assumes the design, its package and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "status_word_params.svh"

module tb;
  import status_word_pkg::*;
  // ========================================================================
  // Signals
  // ========================================================================
  logic        clk_i, reset_n_i, reg_wr_i, reg_rd_i, reset_vector_i, exc_entry_i;
  logic        exc_return_i, branch_exchange_i, exec_attempt_i, multi_active_i;
  logic        cond_block_start_i, cond_block_step_i, rd_d = 1'b0;
  logic [31:0] reg_wdata_i, reg_rdata_o, vector_value_i, stacked_status_word_i;
  logic [31:0] branch_target_i, status_word_o, w, v;
  logic [5:0]  exc_number_i;
  logic [3:0]  reg_addr_i, multi_next_reg_i, cond_block_first_i, cond_block_mask_i;
  logic [3:0]  resume_reg_o, cond_code_o, r, f;
  logic [4:0]  irq_index_o, n;
  logic        exec_allowed_o, fault_o, lockup_o, resume_valid_o, in_cond_block_o;
  exc_kind_t   exc_kind_o;
  logic [31:0] exp_q[$];
  logic [5:0]  ev_q[$];
  int          err_count = 0, n_checks = 0, cyc = 0;
  logic [5:0]  codes[8] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0b, 6'h0e, 6'h0f};
  logic [5:0]  res[4] = '{6'h01, 6'h07, 6'h0c, 6'h2e};
  exc_kind_t   kinds[8] = '{KIND_FIXED, KIND_FIXED, KIND_FAULT, KIND_FAULT,
                            KIND_FAULT, KIND_SYSTEM, KIND_SYSTEM, KIND_SYSTEM};
  localparam logic [8:0] P_RV = 9'h100, P_EN = 9'h080, P_RET = 9'h040, P_BR = 9'h020;
  localparam logic [8:0] P_EX = 9'h010, P_CS = 9'h008, P_ST = 9'h004, P_WR = 9'h002;

  status_word_exec_state u_status_word_exec_state (.*);

  // ========================================================================
  // Tasks
  // ========================================================================
  // Compares a seen value with its expectation and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Drives one cycle of pulses just after an edge.
  task automatic step(input logic [8:0] p, input logic [3:0] a = 4'h0, input logic [31:0] d = 0);
    @(posedge clk_i);
    {reset_vector_i, exc_entry_i, exc_return_i, branch_exchange_i, exec_attempt_i,
     cond_block_start_i, cond_block_step_i, reg_wr_i, reg_rd_i} <= p;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
  endtask : step

  // Reads and notes the word expected.
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    step(9'h001, a);
  endtask : rd

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    if (exp_q.size() != 0 || ev_q.size() != 0) err_count++;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // ========================================================================
  // Clock, timeout and output watcher
  // ========================================================================
  always #5 clk_i = !clk_i;

  // Checks each result against the oldest note; cuts hangs.
  always @(posedge clk_i) begin
    rd_d <= reg_rd_i && reset_n_i;
    cyc  <= cyc + 1;
    if (rd_d) check(reg_rdata_o, exp_q.pop_front());
    if ((fault_o && !lockup_o) || resume_valid_o) begin
      if (ev_q.size() == 0) check({resume_valid_o, fault_o, resume_reg_o}, 6'h00);
      else check({resume_valid_o, fault_o, resume_reg_o}, ev_q.pop_front());
    end
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    {clk_i, reset_n_i, reg_wr_i, reg_rd_i, reset_vector_i, exc_entry_i, exc_return_i} = 0;
    {branch_exchange_i, exec_attempt_i, multi_active_i, cond_block_start_i} = 0;
    {cond_block_step_i, reg_addr_i, reg_wdata_i, vector_value_i} = 0;
    {stacked_status_word_i, branch_target_i, exc_number_i, multi_next_reg_i} = 0;
    {cond_block_first_i, cond_block_mask_i} = 0;
    void'($urandom(32'h4cb8));
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // Reset values, ignored write, unmapped read, reset vector load.
    rd(0, 32'h01000000);
    step(P_WR, 0, 32'hffffffff);
    rd(0, 32'h01000000);
    rd(4, 0);
    rd(4'hc, 0);
    v = $urandom;
    vector_value_i <= v;
    step(P_RV);
    rd(0, {7'h00, v[0], 24'h000000});
    // Branch exchanges, the last one clearing the state bit.
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      if (i == 3) w[0] = 1'b0;
      branch_target_i <= w;
      step(P_BR);
      step(0);
      #1 check(exec_allowed_o, w[0]);
    end
    // Execution with the state bit clear faults; the seen flag clears by write.
    ev_q.push_back(6'h10);
    step(P_EX);
    step(0);
    rd(8, 32'h1);
    step(P_WR, 8, 32'h1);
    rd(8, 0);
    branch_target_i <= 32'h1;
    step(P_BR);
    // Interrupted multiple transfer, then return and resume.
    n = 5'($urandom_range(29, 0));
    r = 4'($urandom_range(15, 1));
    v = $urandom | 32'h1;
    exc_number_i     <= 6'h10 + 6'(n);
    vector_value_i   <= v;
    multi_active_i   <= 1'b1;
    multi_next_reg_i <= r;
    step(P_EN);
    w = {7'h00, 1'b1, 8'h00, r, 2'b00, 4'h0, 6'h10 + 6'(n)};
    rd(0, w);
    multi_active_i <= 1'b0;
    step(0);
    #1 check(exc_kind_o, KIND_IRQ);
    check(irq_index_o, n);
    w[24] = 1'($urandom);
    stacked_status_word_i <= w;
    ev_q.push_back({2'b10, r});
    step(P_RET);
    step(0);
    #1 check(exec_allowed_o, w[24]);
    // Every named exception number but thread, then reserved ones that are ignored.
    for (int i = 0; i < 8; i++) begin
      exc_number_i <= codes[i];
      step(P_EN);
      rd(0, {7'h00, 1'b1, 18'h00000, codes[i]});
      step(0);
      #1 check(exc_kind_o, kinds[i]);
    end
    for (int i = 0; i < 4; i++) begin
      exc_number_i <= res[i];
      step(P_EN);
      rd(0, {7'h00, 1'b1, 18'h00000, 6'h0f});
      rd(8, 32'h4);
      step(0);
      #1 check(exc_kind_o, KIND_SYSTEM);
    end
    // Conditional block: empty mask ignored, mask 4'h1 runs four steps.
    f = 4'($urandom);
    cond_block_first_i <= f;
    step(P_CS);
    step(0);
    #1 check(in_cond_block_o, 0);
    cond_block_mask_i <= 4'h1;
    step(P_CS);
    rd(0, {5'h00, 2'b01, 1'b1, 8'h00, f, 2'b00, 4'h0, 6'h0f});
    step(0);
    #1 check(cond_code_o, f);
    for (int k = 1; k <= 4; k++) begin
      step(P_ST);
      step(0);
      #1 check(in_cond_block_o, k < 4);
      if (k < 4) check(cond_code_o[3:1], f[3:1]);
    end
    // Lockup on a bad execution once enabled.
    step(P_WR, 4, 32'h1);
    branch_target_i <= 32'h0;
    step(P_BR);
    step(P_EX);
    step(0);
    #1 check({lockup_o, exec_allowed_o}, 2'b10);
    repeat (3) step(0);
    end_of_test();
  end
endmodule : tb

`default_nettype wire
